// ==== core/spi_crc_defines.vh ====
`ifndef SPI_CRC_DEFINES_VH
`define SPI_CRC_DEFINES_VH

// ------------------------------------------------------------
// data path sizes
// ------------------------------------------------------------
`define WORD_W 16
`define FIFO_DEPTH 8
`define FIFO_AW 3

// ------------------------------------------------------------
// frame counts: last edge index and last bit index per format
// ------------------------------------------------------------
`define EDGE_LAST8 5'h0F
`define EDGE_LAST16 5'h1F
`define BIT_LAST8 4'h7
`define BIT_LAST16 4'hF

// ------------------------------------------------------------
// timing and reset values
// ------------------------------------------------------------
// master half period in i_mclk cycles is this value shifted by
// the baud divider; at least 4 so synchronised inputs settle
`define HALF_BASE 10'h004
`define CRC_INIT 16'h0000
`define WORD_ZERO 16'h0000

`endif

// ==== core/spi_crc_status.v ====
// How it works
// - separate transmit and receive checksum calculators
// - one bit per sampling edge, programmed polynomial
// - eight or sixteen bit checksum by format
// - setting checksum enable clears both calculators
// - checksum sent after last written word
// - receive-only: checksum follows last received word
// - buffered data goes out before checksum
// - calculators frozen during checksum frame
// - received checksum mismatch sets flag, irq
// - slave checksum follows clock without enable
// - slave checksum runs with select high
// - clear checksum between slave selections
// - empty flag set when no word is queued, write clears
// - not-empty set on receive, read clears
// - busy is hardware only
// - busy set at start, not master bidir receive
// - busy cleared at end, disable, fault
// - continuous: master busy high, slave dips
`include "spi_crc_defines.vh"
`default_nettype none

module spi_crc_status (
   input wire i_mclk,
   input wire i_nrst,
   input wire i_peripheral_enable,
   input wire i_master_select,
   input wire i_clock_phase_select,
   input wire i_clock_polarity_select,
   input wire i_low_bit_first_order,
   input wire [2:0] i_baud_divider,
   input wire i_software_select_management,
   input wire i_internal_select_level,
   input wire i_checksum_enable,
   input wire i_checksum_sixteen_bit,
   input wire i_half_duplex_line_mode,
   input wire i_half_duplex_output_drive,
   input wire i_receive_only_select,
   input wire i_send_checksum_next,
   input wire i_error_interrupt_enable,
   input wire [15:0] i_checksum_polynomial,
   input wire i_clear_checksum_mismatch,
   input wire i_clear_master_fault,
   input wire i_data_write,
   input wire [15:0] i_data_write_value,
   output wire o_data_write_ready,
   input wire i_data_read,
   output reg [15:0] o_data_read_value,
   output wire o_tx_buffer_empty_flag,
   output reg o_rx_not_empty_flag,
   output reg o_busy_flag,
   output reg o_checksum_mismatch_flag,
   output reg o_master_fault_flag,
   output reg o_error_irq,
   output reg [15:0] o_transmit_checksum_register,
   output reg [15:0] o_receive_checksum_register,
   input wire i_sck,
   output reg o_sck,
   output wire o_sck_oe,
   input wire i_mosi,
   output wire o_mosi,
   output wire o_mosi_oe,
   input wire i_miso,
   output wire o_miso,
   output wire o_miso_oe,
   input wire i_select_n
);

   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_RUN = 2'b10;

   // ---------------------------------------------------------
   // helpers
   // ---------------------------------------------------------
   // bit of a word sent at position idx for the chosen order
   function pick;
      input [15:0] w;
      input [3:0] idx;
      input lsb;
      input six;
      reg [3:0] p;
      begin
         p = lsb ? idx : ((six ? `BIT_LAST16 : `BIT_LAST8) - idx);
         pick = w[p];
      end
   endfunction

   // one serial step of the checksum, upper byte kept clear in 8 bit
   function [15:0] crc_step;
      input [15:0] crc;
      input b;
      input [15:0] poly;
      input six;
      reg fb;
      reg [15:0] n;
      begin
         fb = (six ? crc[15] : crc[7]) ^ b;
         n = {crc[14:0], 1'b0} ^ (fb ? poly : `WORD_ZERO);
         crc_step = six ? n : {8'h00, n[7:0]};
      end
   endfunction

   // ---------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------
   reg sck_m;
   reg sck_s;
   reg sck_p;
   reg mosi_m;
   reg mosi_s;
   reg miso_m;
   reg miso_s;
   reg sel_m;
   reg sel_n_s;

   // two stages each; only sck_s feeds the edge history
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         sck_m <= 1'b0;
         sck_s <= 1'b0;
         sck_p <= 1'b0;
         mosi_m <= 1'b0;
         mosi_s <= 1'b0;
         miso_m <= 1'b0;
         miso_s <= 1'b0;
         sel_m <= 1'b1;
         sel_n_s <= 1'b1;
      end else begin
         sck_m <= i_sck;
         sck_s <= sck_m;
         sck_p <= sck_s;
         mosi_m <= i_mosi;
         mosi_s <= mosi_m;
         miso_m <= i_miso;
         miso_s <= miso_m;
         sel_m <= i_select_n;
         sel_n_s <= sel_m;
      end
   end

   // ---------------------------------------------------------
   // mode decode
   // ---------------------------------------------------------
   reg [1:0] mstate;
   reg [9:0] div;
   reg lead_next;
   reg [4:0] ecnt;
   reg in_frame;
   reg [15:0] word;
   reg [15:0] rx_sh;
   reg tx_bit;
   reg crc_arm;
   reg crc_frame;
   wire clock_polarity_select = i_clock_polarity_select;
   wire clock_phase_select = i_clock_phase_select;
   wire six = i_checksum_sixteen_bit;
   wire lsb = i_low_bit_first_order;
   wire is_master = i_master_select & ~o_master_fault_flag;
   wire enabled = i_peripheral_enable & ~o_master_fault_flag;
   wire bidir_rx = i_half_duplex_line_mode & ~i_half_duplex_output_drive;
   wire rx_mode = i_receive_only_select | bidir_rx;
   wire tx_en = ~rx_mode;
   wire rx_en = ~(i_half_duplex_line_mode & i_half_duplex_output_drive);
   wire selected = i_software_select_management ?
      ~i_internal_select_level : ~sel_n_s;
   wire m_active = enabled & is_master;
   wire s_active = enabled & ~is_master & selected;
   wire fault_now = i_master_select & i_peripheral_enable & selected;
   wire running = (mstate == ST_RUN);

   // ---------------------------------------------------------
   // transmit buffer
   // ---------------------------------------------------------
   wire fifo_valid;
   wire [15:0] fifo_data;
   wire fifo_pop;

   spi_tx_fifo #(
      .WIDTH(`WORD_W),
      .DEPTH(`FIFO_DEPTH),
      .AW(`FIFO_AW)
   ) u_tx_fifo (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_in_valid(i_data_write),
      .o_in_ready(o_data_write_ready),
      .i_in_data(i_data_write_value),
      .o_out_valid(fifo_valid),
      .i_out_ready(fifo_pop),
      .o_out_data(fifo_data)
   );

   // empty means the next word may be loaded; a write fills it
   assign o_tx_buffer_empty_flag = ~fifo_valid;

   // ---------------------------------------------------------
   // edge events from master divider or slave clock pin
   // ---------------------------------------------------------
   wire [9:0] half = `HALF_BASE << i_baud_divider;
   wire m_edge = running & (div == half - 10'h001);
   wire s_lead = ~is_master & (sck_s != clock_polarity_select) & (sck_p == clock_polarity_select);
   wire s_trail = ~is_master & (sck_s == clock_polarity_select) & (sck_p != clock_polarity_select);
   wire ev_lead = is_master ? (m_edge & lead_next) : s_lead;
   wire ev_trail = is_master ? (m_edge & ~lead_next) : s_trail;
   wire sample_ev = clock_phase_select ? ev_trail : ev_lead;
   wire shift_ev = clock_phase_select ? ev_lead : ev_trail;
   wire eng_on = is_master ? running : s_active;
   wire [4:0] edge_last = six ? `EDGE_LAST16 : `EDGE_LAST8;
   wire [3:0] bit_last = six ? `BIT_LAST16 : `BIT_LAST8;
   wire [3:0] bidx = ecnt[4:1];
   wire [3:0] sidx = clock_phase_select ? bidx : bidx + 4'h1;
   wire end_edge = eng_on & (ev_lead | ev_trail) & (ecnt == edge_last);
   wire first_lead = eng_on & ev_lead & ~in_frame;
   wire rx_b = (is_master ^ i_half_duplex_line_mode) ? miso_s : mosi_s;
   wire [15:0] rx_nx = lsb ? {rx_b, rx_sh[15:1]} : {rx_sh[14:0], rx_b};
   wire [15:0] rx_word = six ? rx_nx :
      (lsb ? {8'h00, rx_nx[15:8]} : {8'h00, rx_nx[7:0]});
   wire data_done = eng_on & sample_ev & (bidx == bit_last);
   // queued data wins over a pending checksum frame
   wire crc_go = data_done & crc_arm & ~crc_frame &
      (rx_mode | ~fifo_valid);
   wire next_crc_frame = crc_go | (crc_frame & ~data_done);
   // checksum frame reuses the frozen transmit value
   wire [15:0] src = crc_frame ? o_transmit_checksum_register :
      (fifo_valid ? fifo_data : `WORD_ZERO);
   wire [15:0] cur_word = in_frame ? word : src;
   wire have_work = next_crc_frame | rx_mode | fifo_valid;

   assign fifo_pop = first_lead & ~crc_frame & tx_en & fifo_valid;

   // ---------------------------------------------------------
   // master clock generator
   // ---------------------------------------------------------
   // a disable lets the frame in flight finish; a fault aborts it
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         mstate <= ST_IDLE;
         div <= 10'h000;
         lead_next <= 1'b1;
         o_sck <= 1'b0;
      end else begin
         case (mstate)
            ST_IDLE: begin
               div <= 10'h000;
               lead_next <= 1'b1;
               o_sck <= clock_polarity_select;
               if (m_active & have_work) begin
                  mstate <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (~is_master) begin
                  mstate <= ST_IDLE;
               end else if (m_edge) begin
                  div <= 10'h000;
                  lead_next <= ~lead_next;
                  o_sck <= ~o_sck;
                  if (end_edge & ~(m_active & have_work)) begin
                     mstate <= ST_IDLE;
                  end
               end else begin
                  div <= div + 10'h001;
               end
            end
            default: begin
               mstate <= ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------
   // frame engine: edge count, word latch, serial out and in
   // ---------------------------------------------------------
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         ecnt <= 5'h00;
         in_frame <= 1'b0;
         word <= `WORD_ZERO;
         rx_sh <= `WORD_ZERO;
         tx_bit <= 1'b0;
      end else begin
         if (~eng_on) begin
            ecnt <= 5'h00;
            in_frame <= 1'b0;
         end else if (ev_lead | ev_trail) begin
            if (end_edge) begin
               ecnt <= 5'h00;
               in_frame <= 1'b0;
            end else begin
               ecnt <= ecnt + 5'h01;
               in_frame <= 1'b1;
            end
         end
         if (first_lead) begin
            word <= src;
         end
         if (eng_on & sample_ev) begin
            rx_sh <= rx_nx;
         end
         // first bit must stand before the first sampling edge
         if (eng_on & shift_ev & in_frame & ~end_edge) begin
            tx_bit <= pick(cur_word, sidx, lsb, six);
         end else if (~in_frame) begin
            tx_bit <= pick(src, 4'h0, lsb, six);
         end
      end
   end

   // ---------------------------------------------------------
   // checksum calculators and checksum frame control
   // ---------------------------------------------------------
   // a slave follows clock edges whenever checksums are on,
   // whatever the enable or select, so the far end stays in step
   wire crc_tick = sample_ev & i_checksum_enable & ~crc_frame &
      (is_master ? eng_on : 1'b1);

   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_transmit_checksum_register <= `CRC_INIT;
         o_receive_checksum_register <= `CRC_INIT;
         crc_arm <= 1'b0;
         crc_frame <= 1'b0;
      end else begin
         if (~i_checksum_enable) begin
            // held at start value, so setting enable starts clean
            o_transmit_checksum_register <= `CRC_INIT;
            o_receive_checksum_register <= `CRC_INIT;
         end else if (crc_tick) begin
            o_transmit_checksum_register <= crc_step(
               o_transmit_checksum_register, tx_bit,
               i_checksum_polynomial, six);
            o_receive_checksum_register <= crc_step(
               o_receive_checksum_register, rx_b,
               i_checksum_polynomial, six);
         end
         // a request in the cycle that consumes the old one survives
         crc_arm <= i_checksum_enable &
            ((crc_arm & ~crc_go) | i_send_checksum_next);
         crc_frame <= i_checksum_enable & eng_on & next_crc_frame;
      end
   end

   // ---------------------------------------------------------
   // receive buffer and status flags
   // ---------------------------------------------------------
   wire crc_bad = data_done & crc_frame & rx_en &
      (rx_word != o_receive_checksum_register);
   wire m_start = (mstate == ST_IDLE) & m_active & have_work;
   wire m_stop = running & m_edge & end_edge & ~(m_active & have_work);

   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_data_read_value <= `WORD_ZERO;
         o_rx_not_empty_flag <= 1'b0;
         o_checksum_mismatch_flag <= 1'b0;
         o_master_fault_flag <= 1'b0;
         o_error_irq <= 1'b0;
      end else begin
         if (data_done & rx_en) begin
            o_data_read_value <= rx_word;
         end
         // new data in the cycle of a read keeps the flag set
         o_rx_not_empty_flag <= (data_done & rx_en) |
            (o_rx_not_empty_flag & ~i_data_read);
         o_checksum_mismatch_flag <= crc_bad |
            (o_checksum_mismatch_flag & ~i_clear_checksum_mismatch);
         o_master_fault_flag <= fault_now |
            (o_master_fault_flag & ~i_clear_master_fault);
         o_error_irq <= i_error_interrupt_enable &
            (o_checksum_mismatch_flag | o_master_fault_flag);
      end
   end

   // busy has no software write path at all
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_busy_flag <= 1'b0;
      end else if (~enabled | fault_now) begin
         o_busy_flag <= 1'b0;
      end else if (is_master) begin
         // master bidir receive never shows busy
         if (m_start & ~bidir_rx) begin
            o_busy_flag <= 1'b1;
         end else if (m_stop | bidir_rx) begin
            o_busy_flag <= 1'b0;
         end
      end else begin
         // slave drops busy between words, even back to back
         if (first_lead) begin
            o_busy_flag <= 1'b1;
         end else if (data_done | ~s_active) begin
            o_busy_flag <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------
   // pin drive
   // ---------------------------------------------------------
   assign o_sck_oe = is_master & (enabled | running);
   assign o_mosi = tx_bit;
   assign o_mosi_oe = o_sck_oe & tx_en;
   assign o_miso = tx_bit;
   assign o_miso_oe = s_active & tx_en;

endmodule

`default_nettype wire

// ==== core/spi_tx_fifo.v ====
`default_nettype none

module spi_tx_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire i_mclk,
   input wire i_nrst,
   input wire i_in_valid,
   output wire o_in_ready,
   input wire [WIDTH-1:0] i_in_data,
   output wire o_out_valid,
   input wire i_out_ready,
   output wire [WIDTH-1:0] o_out_data
);

   localparam [AW:0] FULL = DEPTH;
   localparam [AW:0] ONE = 1;
   localparam [AW-1:0] STEP = 1;

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wptr;
   reg [AW-1:0] rptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   // honest flags come straight from the fill count
   assign o_in_ready = (count != FULL);
   assign o_out_valid = (count != {(AW+1){1'b0}});
   assign o_out_data = mem[rptr];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   // storage has no reset; only pointers and count carry state
   always @(posedge i_mclk) begin
      if (push) begin
         mem[wptr] <= i_in_data;
      end
   end

   // pointers wrap naturally, depth is a power of two
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         wptr <= {AW{1'b0}};
         rptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wptr <= wptr + STEP;
         end
         if (pop) begin
            rptr <= rptr + STEP;
         end
         if (push & ~pop) begin
            count <= count + ONE;
         end else if (pop & ~push) begin
            count <= count - ONE;
         end
      end
   end

endmodule

`default_nettype wire

// ==== tb/spi_crc_status_monitor.sv ====
`default_nettype none

// ------
// port checker
// ------
module spi_crc_status_monitor (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_peripheral_enable,
   input wire logic i_master_select,
   input wire logic i_half_duplex_line_mode,
   input wire logic i_half_duplex_output_drive,
   input wire logic i_checksum_enable,
   input wire logic i_checksum_sixteen_bit,
   input wire logic i_error_interrupt_enable,
   input wire logic i_clear_checksum_mismatch,
   input wire logic i_data_write,
   input wire logic i_data_read,
   input wire logic o_data_write_ready,
   input wire logic o_tx_buffer_empty_flag,
   input wire logic o_rx_not_empty_flag,
   input wire logic o_busy_flag,
   input wire logic o_checksum_mismatch_flag,
   input wire logic o_master_fault_flag,
   input wire logic o_error_irq,
   input wire logic o_sck,
   input wire logic [15:0] o_transmit_checksum_register,
   input wire logic [15:0] o_receive_checksum_register
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_nrst);

   AST_TXE_WRITE: assert property (
      i_data_write && o_data_write_ready |=> !o_tx_buffer_empty_flag)
      else $error("empty after write");
   AST_EMPTY_READY: assert property (
      o_tx_buffer_empty_flag |-> o_data_write_ready)
      else $error("empty not ready");
   // idle, so no word lands next cycle
   AST_RX_NOT_EMPTY_FLAG_READ: assert property (
      i_data_read && o_rx_not_empty_flag && !o_busy_flag &&
      i_peripheral_enable && !i_half_duplex_line_mode
      |=> !o_rx_not_empty_flag)
      else $error("read kept flag");
   AST_BUSY_OFF: assert property (
      !i_peripheral_enable [*2] |-> !o_busy_flag)
      else $error("busy while disabled");
   AST_BIDIR_QUIET: assert property (
      i_master_select && i_half_duplex_line_mode &&
      !i_half_duplex_output_drive |-> !o_busy_flag)
      else $error("busy in bidir rx");
   AST_CRC_HELD: assert property (
      !i_checksum_enable |=> o_transmit_checksum_register == 16'h0000 &&
      o_receive_checksum_register == 16'h0000)
      else $error("checksum not cleared");
   AST_CRC_WIDTH: assert property (
      !i_checksum_sixteen_bit |-> o_transmit_checksum_register[15:8] ==
      8'h00 && o_receive_checksum_register[15:8] == 8'h00)
      else $error("crc too wide");
   AST_IRQ_SET: assert property (
      i_error_interrupt_enable && o_checksum_mismatch_flag |=> o_error_irq)
      else $error("no irq");
   AST_IRQ_GATE: assert property (
      !i_error_interrupt_enable |=> !o_error_irq)
      else $error("irq masked");
   AST_CRC_STICKY: assert property (
      o_checksum_mismatch_flag && !i_clear_checksum_mismatch
      |=> o_checksum_mismatch_flag)
      else $error("mismatch flag lost");
   AST_FAULT_BUSY: assert property (
      $rose(o_master_fault_flag) |-> ##[0:1] !o_busy_flag)
      else $error("busy on fault");

   COV_RX_WORD: cover property ($rose(o_rx_not_empty_flag));
   COV_CRC_ERR: cover property ($rose(o_checksum_mismatch_flag));
   COV_FAULT: cover property ($rose(o_master_fault_flag));
   COV_BIDIR: cover property (i_half_duplex_line_mode && o_sck);
endmodule

bind spi_crc_status spi_crc_status_monitor i_mon (.*);

`default_nettype wire

// ==== tb/spi_peer_model.sv ====
`default_nettype none

// ------
// serial peer: mode 0, 8 bit, msb first
// ------
module spi_peer_model (
   input wire logic i_sck,
   input wire logic i_mosi,
   output logic o_miso,
   output logic [7:0] o_got,
   output logic o_got_stb
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] q[$];
   logic [7:0] tx_sh = 8'h00, rx_sh = 8'h00;
   int n = 0;

   initial begin
      o_miso = 1'b1;
      o_got = 8'h00;
      o_got_stb = 1'b0;
   end

   // next word, or the inverse when none queued
   task automatic load();
      tx_sh = q.size() ? q.pop_front() : ~tx_sh;
      o_miso = tx_sh[7];
      n = 0;
   endtask

   // sample on rising edge
   always @(posedge i_sck) begin
      rx_sh = {rx_sh[6:0], i_mosi};
      n = n + 1;
      if (n == 8) begin
         o_got = rx_sh;
         o_got_stb = ~o_got_stb;
         n = 0;
      end
   end

   // shift on falling edge
   always @(negedge i_sck) begin
      if (n == 0) begin
         load();
      end else begin
         tx_sh = {tx_sh[6:0], 1'b0};
         o_miso = tx_sh[7];
      end
   end
endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ------
   // pins and state
   // ------
   logic i_mclk = 1'b0, i_nrst = 1'b0, i_peripheral_enable = 1'b0;
   logic i_master_select = 1'b1, i_software_select_management = 1'b1;
   logic i_internal_select_level = 1'b1, i_select_n = 1'b1;
   logic i_clock_phase_select = 1'b0, i_clock_polarity_select = 1'b0;
   logic i_low_bit_first_order = 1'b0, i_checksum_sixteen_bit = 1'b0;
   logic i_checksum_enable = 1'b0, i_half_duplex_line_mode = 1'b0;
   logic i_half_duplex_output_drive = 1'b1, i_receive_only_select = 1'b0;
   logic i_send_checksum_next = 1'b0, i_error_interrupt_enable = 1'b0;
   logic i_clear_checksum_mismatch = 1'b0, i_clear_master_fault = 1'b0;
   logic i_data_write = 1'b0, i_data_read = 1'b0;
   logic [2:0] i_baud_divider = 3'h0;
   logic [15:0] i_checksum_polynomial = 16'h0007;
   logic [15:0] i_data_write_value = 16'h0000;
   logic o_data_write_ready, o_tx_buffer_empty_flag, o_rx_not_empty_flag;
   logic o_busy_flag, o_checksum_mismatch_flag, o_master_fault_flag;
   logic o_error_irq, o_sck, o_sck_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe;
   logic [15:0] o_data_read_value, o_transmit_checksum_register;
   logic [15:0] o_receive_checksum_register;
   wire logic i_sck, i_mosi, i_miso;
   logic peer_miso, peer_stb, tgl = 1'b0, mon_on = 1'b1;
   logic [7:0] peer_got;
   logic [15:0] exp_tx[$], exp_rx[$];
   int err_total = 0, n_checks = 0, cyc = 0;

   // released lines: sck low, mosi toggles, miso from the peer
   assign i_sck = o_sck_oe ? o_sck : 1'b0;
   assign i_mosi = o_mosi_oe ? o_mosi : tgl;
   assign i_miso = o_miso_oe ? o_miso : peer_miso;

   spi_crc_status i_dut (.*);
   spi_peer_model i_peer (.i_sck(i_sck), .i_mosi(i_mosi),
      .o_miso(peer_miso), .o_got(peer_got), .o_got_stb(peer_stb));

   initial forever #20 i_mclk = ~i_mclk;

   // ------
   // helpers
   // ------
   task automatic tick(input int k);
      repeat (k) @(posedge i_mclk);
   endtask

   task automatic chk(input string what, input logic [15:0] exp, got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // serial checksum in line order, msb feedback
   function automatic logic [7:0] crc8(input logic [7:0] c, d, p);
      for (int i = 7; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? p : 8'h00);
      return c;
   endfunction

   // checksum clear sequence
   task automatic clr_crc();
      tick(1);
      i_peripheral_enable <= 1'b0;
      tick(1);
      i_checksum_enable <= 1'b0;
      tick(1);
      i_checksum_enable <= 1'b1;
      tick(1);
      i_peripheral_enable <= 1'b1;
      tick(1);
      chk("tx_crc_clear", 16'h0000, o_transmit_checksum_register);
      chk("rx_crc_clear", 16'h0000, o_receive_checksum_register);
   endtask

   // n words then the checksum word; bad corrupts it
   task automatic run_frames(input int n, input logic bad);
      logic [7:0] d[4];
      logic [7:0] ct = 8'h00, cr = 8'h00, r, p;
      logic pb = 1'b0;
      int falls = 0, t;
      p = 8'($urandom) | 8'h01;
      i_checksum_polynomial <= {8'h00, p};
      for (int k = 0; k < n; k++) begin
         d[k] = 8'($urandom);
         r = 8'($urandom);
         ct = crc8(ct, d[k], p);
         cr = crc8(cr, r, p);
         exp_tx.push_back({8'h00, d[k]});
         exp_rx.push_back({8'h00, r});
         i_peer.q.push_back(r);
      end
      r = bad ? ~cr : cr;
      exp_tx.push_back({8'h00, ct});
      exp_rx.push_back({8'h00, r});
      i_peer.q.push_back(r);
      i_peer.load();
      for (int k = 0; k < n; k++) begin
         tick(1);
         i_data_write <= 1'b1;
         i_data_write_value <= {8'h00, d[k]};
      end
      tick(1);
      i_data_write <= 1'b0;
      i_send_checksum_next <= 1'b1;
      tick(1);
      i_send_checksum_next <= 1'b0;
      for (t = 0; t < 4000 && (exp_rx.size() > 0 || o_busy_flag); t++) begin
         tick(1);
         if (pb && !o_busy_flag)
            falls++;
         pb = o_busy_flag;
      end
      tick(4);
      chk("drained", 16'h0, 16'(t == 4000));
      chk("busy_drops", 16'h1, 16'(falls));
      chk("words_left", 16'h0, 16'(exp_tx.size()));
      chk("tx_crc", {8'h00, ct}, o_transmit_checksum_register);
      chk("rx_crc", {8'h00, cr}, o_receive_checksum_register);
      chk("crc_err", 16'(bad), o_checksum_mismatch_flag);
      chk("err_irq", 16'(bad), o_error_irq);
      chk("tx_empty", 16'h1, o_tx_buffer_empty_flag);
      i_clear_checksum_mismatch <= bad;
      tick(1);
      i_clear_checksum_mismatch <= 1'b0;
      tick(2);
      chk("crc_err_clr", 16'h0, o_checksum_mismatch_flag);
   endtask

   // ------
   // result watchers
   // ------
   always @(peer_stb) begin
      if (mon_on && i_nrst)
         chk("mosi_word", exp_tx.size() ? exp_tx.pop_front() : 16'hFFFF,
            {8'h00, peer_got});
   end

   // read each received word
   always @(posedge i_mclk) begin
      if (o_rx_not_empty_flag === 1'b1 && i_data_read !== 1'b1) begin
         if (mon_on)
            chk("rx_word", exp_rx.size() ? exp_rx.pop_front() : 16'hFFFF,
               o_data_read_value);
         i_data_read <= 1'b1;
      end else begin
         i_data_read <= 1'b0;
      end
   end

   // hang guard, far above run length
   always @(posedge i_mclk) begin
      tgl <= ~tgl;
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         final_report();
      end
   end

   // ------
   // main sequence
   // ------
   initial begin
      int nb;
      void'($urandom(32'h1EE479D2));
      tick(12);
      i_nrst <= 1'b1;
      tick(3);
      chk("empty_rst", 16'h1, o_tx_buffer_empty_flag);
      chk("busy_rst", 16'h0, o_busy_flag);
      chk("rx_not_empty_flag_rst", 16'h0, o_rx_not_empty_flag);
      i_error_interrupt_enable <= 1'b1;
      clr_crc();
      run_frames(3, 1'b0);
      clr_crc();
      run_frames(1, 1'b1);
      mon_on <= 1'b0;
      tick(1);
      i_data_write <= 1'b1;
      i_data_write_value <= 16'h00A5;
      tick(1);
      i_data_write <= 1'b0;
      tick(12);
      chk("busy_run", 16'h1, o_busy_flag);
      i_internal_select_level <= 1'b0;
      tick(3);
      chk("fault", 16'h1, o_master_fault_flag);
      chk("busy_fault", 16'h0, o_busy_flag);
      i_internal_select_level <= 1'b1;
      i_clear_master_fault <= 1'b1;
      tick(1);
      i_clear_master_fault <= 1'b0;
      clr_crc();
      i_peer.load();
      // rx-only busy up, bidir rx busy down
      for (int m = 0; m < 2; m++) begin
         tick(1);
         i_peripheral_enable <= 1'b0;
         i_receive_only_select <= (m == 0);
         i_half_duplex_line_mode <= (m == 1);
         i_half_duplex_output_drive <= 1'b0;
         i_baud_divider <= 3'(m);
         tick(1);
         i_peripheral_enable <= 1'b1;
         nb = 0;
         repeat (100) begin
            tick(1);
            nb += (o_busy_flag === 1'b1);
         end
         i_peripheral_enable <= 1'b0;
         tick(150);
         chk("busy_seen", 16'(m == 0), 16'(nb > 0));
      end
      final_report();
   end
endmodule

`default_nettype wire
